// file: hw/cgfs_dev.sv
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cgfs_dev (
	input wire logic clk,
	input wire logic reset,
	cgfs_if.slave lnk,
	input wire logic hw_freq_strap_b0,
	input wire logic hw_freq_strap_b1,
	input wire logic hw_freq_strap_b2,
	input wire logic hw_freq_strap_b3,
	input wire logic pci_clock_out_zero,
	input wire logic cpu_stop_n,
	input wire logic power_down_n,
	input wire logic [cgfs_pkg::NOUT-1:0] clk_src,
	output logic [cgfs_pkg::NOUT-1:0] clk_out,
	output logic [3:0] freq_idx,
	output logic [11:0] cpu_mhz_x10,
	output logic [9:0] pci_mhz_x10,
	output logic reference_clock_out_is_out
);
	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_RX = 3'b001,
		D_RACK = 3'b010,
		D_TX = 3'b011,
		D_TACK = 3'b100
	} cgfs_dst_t;
	typedef enum logic [1:0] {
		PH_ADDR = 2'b00,
		PH_CMD = 2'b01,
		PH_CNT = 2'b10,
		PH_DATA = 2'b11
	} cgfs_ph_t;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [8:0] pins_s;
	logic scl_s;
	logic sda_s;
	logic [3:0] strap_s;
	logic mode_s;
	logic stop_n_s;
	logic pd_n_s;
	cgfs_sync #(.WIDTH(9)) u_sync (
		.clk(clk),
		.reset(reset),
		.d({power_down_n, cpu_stop_n, pci_clock_out_zero,
			hw_freq_strap_b3, hw_freq_strap_b2, hw_freq_strap_b1,
			hw_freq_strap_b0, lnk.sda, lnk.scl}),
		.q(pins_s)
	);
	assign scl_s = pins_s[0];
	assign sda_s = pins_s[1];
	assign strap_s = pins_s[5:2];
	assign mode_s = pins_s[6];
	assign stop_n_s = pins_s[7];
	assign pd_n_s = pins_s[8];

	// ----------------------------------------------------------------
	// strap latch
	// ----------------------------------------------------------------
	logic [1:0] wait_r;
	logic [3:0] strap_r;
	logic mode_r;
	logic strap_go;
	// waits for the synchroniser to fill so the straps are real levels
	assign strap_go = (wait_r == cgfs_pkg::STRAP_WAIT - 2'h1);
	always_ff @(posedge clk) begin
		if (reset) begin
			wait_r <= 2'h0;
		end else if (wait_r != cgfs_pkg::STRAP_WAIT) begin
			wait_r <= wait_r + 2'h1;
		end
	end
	// caught once; later pin activity (clock toggling) is ignored
	always_ff @(posedge clk) begin
		if (reset) begin
			strap_r <= 4'h0;
			mode_r <= 1'b1;
		end else if (strap_go) begin
			strap_r <= strap_s;
			mode_r <= mode_s;
		end
	end

	// ----------------------------------------------------------------
	// link event detection
	// ----------------------------------------------------------------
	logic scl_d_r;
	logic sda_d_r;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	always_ff @(posedge clk) begin
		if (reset) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end
	assign scl_rise = scl_s & ~scl_d_r;
	assign scl_fall = ~scl_s & scl_d_r;
	// data edges with clock high frame a transfer
	assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;

	// ----------------------------------------------------------------
	// serial slave
	// ----------------------------------------------------------------
	cgfs_dst_t st_r;
	cgfs_ph_t ph_r;
	logic [3:0] cnt_r;
	logic [7:0] sh_r;
	logic [2:0] ptr_r;
	logic [2:0] ptr_nxt;
	logic sda_oe_r;
	logic [7:0] ctl_r [cgfs_pkg::NREG];
	logic [7:0] rd_byte;
	logic addr_hit;
	logic wr_go;
	logic byte_done;
	assign byte_done = scl_fall & (cnt_r == cgfs_pkg::BIT_ACK);
	assign addr_hit = (sh_r[7:1] == cgfs_pkg::SLV_ADDR);
	assign ptr_nxt = (ptr_r == cgfs_pkg::PTR_MAX) ? ptr_r : ptr_r + 3'h1;
	// strap field of the status byte comes from the once-caught strap latch, not the control byte
	assign rd_byte = (ptr_r == cgfs_pkg::REG_STRAP) ?
		{strap_r, ctl_r[cgfs_pkg::REG_STRAP][3:0]} :
		(ptr_r < 3'(cgfs_pkg::NREG)) ? ctl_r[ptr_r] : 8'h00;
	// a data byte lands only at the end of its ack clock
	assign wr_go = (st_r == D_RACK) & scl_fall & (ph_r == PH_DATA) &
		(ptr_r < 3'(cgfs_pkg::NREG));
	assign lnk.sda_o_s = 1'b0;
	assign lnk.sda_oe_s = sda_oe_r;

	// sda only moves on detected scl falls, i.e. while scl is low
	always_ff @(posedge clk) begin
		if (reset) begin
			st_r <= D_IDLE;
			ph_r <= PH_ADDR;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			ptr_r <= 3'h0;
			sda_oe_r <= 1'b0;
		end else if (stop_ev) begin
			st_r <= D_IDLE;
			sda_oe_r <= 1'b0;
		end else if (start_ev) begin
			st_r <= D_RX;
			ph_r <= PH_ADDR;
			cnt_r <= 4'h0;
			ptr_r <= 3'h0;
			sda_oe_r <= 1'b0;
		end else begin
			unique case (st_r)
				D_IDLE: begin
				end
				D_RX: begin
					if (scl_rise) begin
						sh_r <= {sh_r[6:0], sda_s};
						cnt_r <= cnt_r + 4'h1;
					end else if (byte_done) begin
						if (ph_r != PH_ADDR || addr_hit) begin
							st_r <= D_RACK;
							sda_oe_r <= 1'b1;
						end else begin
							st_r <= D_IDLE;
						end
					end
				end
				D_RACK: begin
					if (scl_fall) begin
						cnt_r <= 4'h0;
						if (ph_r == PH_ADDR && sh_r[0]) begin
							st_r <= D_TX;
							sh_r <= rd_byte;
							sda_oe_r <= ~rd_byte[7];
							ptr_r <= ptr_nxt;
						end else begin
							st_r <= D_RX;
							sda_oe_r <= 1'b0;
							// command and count bytes are skipped
							if (ph_r != PH_DATA) begin
								ph_r <= cgfs_ph_t'(ph_r + 2'h1);
							end else begin
								ptr_r <= ptr_nxt;
							end
						end
					end
				end
				D_TX: begin
					if (scl_rise) begin
						cnt_r <= cnt_r + 4'h1;
					end else if (byte_done) begin
						st_r <= D_TACK;
						sda_oe_r <= 1'b0;
					end else if (scl_fall) begin
						sda_oe_r <= ~sh_r[6];
						sh_r <= {sh_r[6:0], 1'b0};
					end
				end
				D_TACK: begin
					if (scl_rise && sda_s) begin
						st_r <= D_IDLE;
					end else if (scl_fall) begin
						st_r <= D_TX;
						cnt_r <= 4'h0;
						sh_r <= rd_byte;
						sda_oe_r <= ~rd_byte[7];
						ptr_r <= ptr_nxt;
					end
				end
				default: begin
					st_r <= D_IDLE;
					sda_oe_r <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// control bytes
	// ----------------------------------------------------------------
	// reserved bits keep their power-up value; only masked bits move
	for (genvar g = 0; g < cgfs_pkg::NREG; g++) begin : g_reg
		always_ff @(posedge clk) begin
			if (reset) begin
				ctl_r[g] <= cgfs_pkg::REG_RST[g];
			end else if (wr_go && ptr_r == 3'(g)) begin
				ctl_r[g] <= (ctl_r[g] & ~cgfs_pkg::REG_WMASK[g]) |
					(sh_r & cgfs_pkg::REG_WMASK[g]);
			end
		end
	end

	// ----------------------------------------------------------------
	// frequency select
	// ----------------------------------------------------------------
	logic [7:0] fsel;
	logic [3:0] sw_code;
	logic [3:0] sel_code;
	assign fsel = ctl_r[cgfs_pkg::REG_FSEL];
	assign sw_code = {fsel[cgfs_pkg::FSEL_B3], fsel[cgfs_pkg::FSEL_B2],
		fsel[cgfs_pkg::FSEL_B1], fsel[cgfs_pkg::FSEL_B0]};
	assign sel_code = fsel[cgfs_pkg::FSEL_SRC] ? sw_code : strap_r;
	always_ff @(posedge clk) begin
		if (reset) begin
			freq_idx <= 4'h0;
			cpu_mhz_x10 <= 12'h000;
			pci_mhz_x10 <= 10'h000;
			reference_clock_out_is_out <= 1'b1;
		end else begin
			freq_idx <= sel_code;
			cpu_mhz_x10 <= cgfs_pkg::CPU_X10[sel_code];
			pci_mhz_x10 <= cgfs_pkg::PCI_X10[sel_code];
			reference_clock_out_is_out <= mode_r;
		end
	end

	// ----------------------------------------------------------------
	// output gating
	// ----------------------------------------------------------------
	logic [cgfs_pkg::NOUT-1:0] out_en;
	logic [cgfs_pkg::NOUT-1:0] want;
	logic [cgfs_pkg::NOUT-1:0] gate_r;
	logic cpu_halt;
	assign out_en = {ctl_r[5][1], ctl_r[5][0], ctl_r[3][4], ctl_r[3][5],
		ctl_r[2][4:0], ctl_r[2][6], ctl_r[1][0], ctl_r[1][1]};
	assign cpu_halt = ~mode_r & ~stop_n_s;
	assign want = out_en & {cgfs_pkg::NOUT{pd_n_s}} &
		~(cgfs_pkg::CPU_MASK & {cgfs_pkg::NOUT{cpu_halt}}) &
		~({{(cgfs_pkg::NOUT-1){1'b0}}, ~mode_r} << cgfs_pkg::REFERENCE_CLOCK_OUT_IDX);
	// a gate only changes while its source is low, so highs stay whole
	for (genvar g = 0; g < cgfs_pkg::NOUT; g++) begin : g_out
		always_ff @(posedge clk) begin
			if (reset) begin
				gate_r[g] <= 1'b0;
				clk_out[g] <= 1'b0;
			end else begin
				if (!clk_src[g]) begin
					gate_r[g] <= want[g];
				end
				clk_out[g] <= clk_src[g] & gate_r[g];
			end
		end
	end
endmodule : cgfs_dev
`default_nettype wire

// file: hw/cgfs_pkg.sv
`default_nettype none
package cgfs_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int LINK_HZ = 100_000;
	// quarter of a serial bit, rounded up so the link never runs fast
	localparam int QTR_CYC = (CLK_HZ + 4 * LINK_HZ - 1) / (4 * LINK_HZ);
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	// ----------------------------------------------------------------
	// serial link
	// ----------------------------------------------------------------
	localparam logic [6:0] SLV_ADDR = 7'h69;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [2:0] PTR_MAX = 3'h7;
	// ----------------------------------------------------------------
	// control bytes
	// ----------------------------------------------------------------
	localparam int NREG = 6;
	localparam logic [2:0] REG_FSEL = 3'h0;
	localparam logic [2:0] REG_STRAP = 3'h4;
	localparam int FSEL_SRC = 3;
	localparam int FSEL_B0 = 4;
	localparam int FSEL_B1 = 5;
	localparam int FSEL_B2 = 6;
	localparam int FSEL_B3 = 2;
	localparam logic [7:0] REG_RST [NREG] = '{8'h00, 8'h0B, 8'hFF,
		8'h37, 8'h00, 8'h03};
	localparam logic [7:0] REG_WMASK [NREG] = '{8'h7C, 8'h0B, 8'h5F,
		8'h77, 8'h03, 8'h03};
	// ----------------------------------------------------------------
	// clock outputs
	// ----------------------------------------------------------------
	localparam int NOUT = 12;
	localparam logic [NOUT-1:0] CPU_MASK = 12'h003;
	localparam int REFERENCE_CLOCK_OUT_IDX = 10;
	// frequencies in tenths of a MHz, indexed by the 4-bit select code
	localparam logic [11:0] CPU_X10 [16] = '{12'h596, 12'h564, 12'h50A,
		12'h4D8, 12'h29C, 12'h3EA, 12'h33E, 12'h535, 12'h4B0, 12'h47E,
		12'h44C, 12'h384, 12'h438, 12'h41A, 12'h406, 12'h3B6};
	localparam logic [9:0] PCI_X10 [16] = '{10'h166, 10'h159, 10'h143,
		10'h136, 10'h14E, 10'h14D, 10'h14D, 10'h14D, 10'h12C, 10'h17F,
		10'h16F, 10'h12C, 10'h168, 10'h15E, 10'h157, 10'h13D};
	// ----------------------------------------------------------------
	// controller register port
	// ----------------------------------------------------------------
	localparam logic [3:0] H_CTRL = 4'h0;
	localparam logic [3:0] H_STAT = 4'h1;
	localparam logic [3:0] H_DATA0 = 4'h2;
	localparam logic [3:0] H_DATA5 = 4'h7;
endpackage : cgfs_pkg
`default_nettype wire

// file: hw/cgfs_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cgfs_if;
	// open-drain wires with pull-ups: low wins when any end drives low
	logic scl_o_m;
	logic scl_oe_m;
	logic sda_o_m;
	logic sda_oe_m;
	logic sda_o_s;
	logic sda_oe_s;
	logic scl;
	logic sda;
	assign scl = ~(scl_oe_m & ~scl_o_m);
	assign sda = ~((sda_oe_m & ~sda_o_m) | (sda_oe_s & ~sda_o_s));
	modport master (output scl_o_m, output scl_oe_m, output sda_o_m,
		output sda_oe_m, input scl, input sda);
	modport slave (output sda_o_s, output sda_oe_s, input scl,
		input sda);
endinterface : cgfs_if
`default_nettype wire

// file: hw/cgfs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cgfs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;
	// ----------------------------------------------------------------
	// two-stage synchroniser; first stage feeds only the second
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_r <= '1;
			q <= '1;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : cgfs_sync
`default_nettype wire

// file: hw/cgfs_host.sv
`timescale 1ns/1ps
`default_nettype none
module cgfs_host (
	input wire logic clk,
	input wire logic reset,
	cgfs_if.master lnk,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata
);
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_START = 2'b01,
		H_BIT = 2'b10,
		H_STOP = 2'b11
	} cgfs_hst_t;

	// ----------------------------------------------------------------
	// state and pacing
	// ----------------------------------------------------------------
	cgfs_hst_t st_r;
	logic [7:0] div_r;
	logic [1:0] q_r;
	logic [3:0] bp_r;
	logic [3:0] bt_r;
	logic [7:0] sh_r;
	logic dir_r;
	logic [2:0] num_r;
	logic nack_r;
	logic scl_oe_r;
	logic sda_oe_r;
	logic [7:0] data_r [6];
	logic sda_s;
	logic tick;
	logic go;
	logic rx;
	logic last;
	logic [7:0] cur;
	logic drv;
	logic [3:0] total;
	cgfs_sync #(.WIDTH(1)) u_sync (
		.clk(clk),
		.reset(reset),
		.d(lnk.sda),
		.q(sda_s)
	);
	assign tick = (div_r == 8'(cgfs_pkg::QTR_CYC - 1));
	assign go = wr & (addr == cgfs_pkg::H_CTRL) & wdata[0] &
		(st_r == H_IDLE) & (wdata[6:4] != 3'h0);
	assign rx = dir_r & (bp_r != 4'h0);
	assign total = dir_r ? {1'b0, num_r} + 4'h1 : {1'b0, num_r} + 4'h3;
	assign last = (bp_r == total - 4'h1);
	// every write starts at control byte 0 and runs in order
	assign cur = (bp_r == 4'h0) ? {cgfs_pkg::SLV_ADDR, dir_r} :
		(bp_r == 4'h1) ? 8'h00 :
		(bp_r == 4'h2) ? {5'h00, num_r} :
		data_r[3'(bp_r - 4'h3)];
	assign drv = (bt_r == cgfs_pkg::BIT_ACK) ? (rx & ~last) :
		(~rx & ~cur[3'h7 - bt_r[2:0]]);
	assign lnk.scl_o_m = 1'b0;
	assign lnk.sda_o_m = 1'b0;
	assign lnk.scl_oe_m = scl_oe_r;
	assign lnk.sda_oe_m = sda_oe_r;

	always_ff @(posedge clk) begin
		if (reset || go || tick) begin
			div_r <= 8'h00;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// bit sequencer: q0 set data, q1 clock up, q2 sample, q3 clock down
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			st_r <= H_IDLE;
			q_r <= 2'h0;
			bp_r <= 4'h0;
			bt_r <= 4'h0;
			sh_r <= 8'h00;
			nack_r <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (go) begin
			st_r <= H_START;
			q_r <= 2'h0;
			nack_r <= 1'b0;
		end else if (tick && st_r != H_IDLE) begin
			q_r <= q_r + 2'h1;
			unique case (st_r)
				H_START: begin
					if (q_r == 2'h1) begin
						sda_oe_r <= 1'b1;
					end else if (q_r == 2'h3) begin
						scl_oe_r <= 1'b1;
						st_r <= H_BIT;
						bp_r <= 4'h0;
						bt_r <= 4'h0;
					end
				end
				H_BIT: begin
					unique case (q_r)
						2'h0: sda_oe_r <= drv;
						2'h1: scl_oe_r <= 1'b0;
						2'h2: begin
							// the ack slot of a read byte is ours, not data
							if (bt_r != cgfs_pkg::BIT_ACK) begin
								if (rx) begin
									sh_r <= {sh_r[6:0], sda_s};
								end
							end else if (!rx) begin
								nack_r <= sda_s;
							end
						end
						2'h3: begin
							scl_oe_r <= 1'b1;
							if (bt_r != cgfs_pkg::BIT_ACK) begin
								bt_r <= bt_r + 4'h1;
							end else if (nack_r || last) begin
								st_r <= H_STOP;
							end else begin
								bp_r <= bp_r + 4'h1;
								bt_r <= 4'h0;
							end
						end
					endcase
				end
				H_STOP: begin
					if (q_r == 2'h0) begin
						sda_oe_r <= 1'b1;
					end else if (q_r == 2'h1) begin
						scl_oe_r <= 1'b0;
					end else if (q_r == 2'h2) begin
						sda_oe_r <= 1'b0;
					end else begin
						st_r <= H_IDLE;
					end
				end
				default: st_r <= H_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	logic rx_done;
	assign rx_done = tick & (st_r == H_BIT) & rx & (q_r == 2'h3) &
		(bt_r == cgfs_pkg::BIT_ACK);
	always_ff @(posedge clk) begin
		if (reset) begin
			dir_r <= 1'b0;
			num_r <= 3'h0;
		end else if (go) begin
			dir_r <= wdata[1];
			num_r <= wdata[6:4];
		end
	end
	for (genvar g = 0; g < 6; g++) begin : g_data
		always_ff @(posedge clk) begin
			if (reset) begin
				data_r[g] <= 8'h00;
			end else if (rx_done && bp_r == 4'(g + 1)) begin
				data_r[g] <= sh_r;
			end else if (wr && addr == cgfs_pkg::H_DATA0 + 4'(g)) begin
				data_r[g] <= wdata;
			end
		end
	end
	// read data stand in the cycle after the strobe only
	always_ff @(posedge clk) begin
		if (reset || !rd) begin
			rdata <= 8'h00;
		end else if (addr == cgfs_pkg::H_CTRL) begin
			rdata <= {1'b0, num_r, 2'b00, dir_r, 1'b0};
		end else if (addr == cgfs_pkg::H_STAT) begin
			rdata <= {6'h00, nack_r, st_r != H_IDLE};
		end else if (addr >= cgfs_pkg::H_DATA0 &&
			addr <= cgfs_pkg::H_DATA5) begin
			rdata <= data_r[3'(addr - cgfs_pkg::H_DATA0)];
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule : cgfs_host
`default_nettype wire

// file: dv/cgfs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cgfs_asserts (
	input wire logic clk,
	input wire logic reset,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_oe_s,
	input wire logic [11:0] clk_src,
	input wire logic [11:0] clk_out,
	input wire logic [3:0] freq_idx,
	input wire logic reference_clock_out_is_out,
	input wire logic cpu_stop_n,
	input wire logic power_down_n
);
	// ----------------------------------------
	// frame tracking on the resolved wires
	// ----------------------------------------
	logic scl_q_r, sda_q_r, act_r, dir_r;
	logic [3:0] bit_r, byte_r, up_r;
	logic [5:0] pd_r, cs_r;
	// edges of the wires as seen one clock late
	wire start_w = scl && scl_q_r && sda_q_r && !sda;
	wire stop_w = scl && scl_q_r && !sda_q_r && sda;
	wire rise_w = scl && !scl_q_r;
	// idle level is high, so reset loads ones
	always_ff @(posedge clk) begin
		scl_q_r <= reset | scl;
		sda_q_r <= reset | sda;
	end
	// frame open between start and stop
	always_ff @(posedge clk) begin
		if (reset || stop_w) begin
			act_r <= 1'b0;
		end else if (start_w) begin
			act_r <= 1'b1;
		end
	end
	// bit and byte position, counted on rising serial clock
	always_ff @(posedge clk) begin
		if (reset || start_w) begin
			bit_r <= 4'h0;
			byte_r <= 4'h0;
		end else if (rise_w && bit_r == 4'h8) begin
			bit_r <= 4'h0;
			byte_r <= byte_r + 4'h1;
		end else if (rise_w) begin
			bit_r <= bit_r + 4'h1;
		end
	end
	// direction bit is the eighth bit of the address byte
	always_ff @(posedge clk) begin
		if (reset) begin
			dir_r <= 1'b0;
		end else if (rise_w && byte_r == 4'h0 && bit_r == 4'h7) begin
			dir_r <= sda;
		end
	end
	// saturating counters: the gates only close on a low source phase
	always_ff @(posedge clk) begin
		pd_r <= (reset || power_down_n) ? 6'h00 : pd_r + {5'h00, pd_r != 6'h3F};
		cs_r <= (reset || cpu_stop_n) ? 6'h00 : cs_r + {5'h00, cs_r != 6'h3F};
		up_r <= reset ? 4'h0 : up_r + {3'h0, up_r != 4'hF};
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	property p_addr_ack;
		rise_w && act_r && byte_r == 4'h0 && bit_r == 4'h8 |-> !sda;
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("no address ack");
	property p_wr_ack;
		rise_w && act_r && byte_r != 4'h0 && bit_r == 4'h8 && !dir_r |-> !sda;
	endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("no byte ack");
	property p_dev_edge;
		$changed(sda_oe_s) |-> !scl;
	endproperty
	a_dev_edge: assert property (p_dev_edge) else $error("data moved");
	property p_dev_idle;
		!act_r |-> !sda_oe_s;
	endproperty
	a_dev_idle: assert property (p_dev_idle) else $error("idle drive");
	property p_pd;
		pd_r >= 6'h18 |-> clk_out == 12'h000;
	endproperty
	a_pd: assert property (p_pd) else $error("clocks run in power-down");
	property p_pd_whole;
		(~clk_out & $past(clk_out) & $past(clk_src)) == 12'h000;
	endproperty
	a_pd_whole: assert property (p_pd_whole) else $error("high cut");
	property p_cpu_stop;
		cs_r >= 6'h18 && !reference_clock_out_is_out |-> (clk_out & cgfs_pkg::CPU_MASK) == 12'h000;
	endproperty
	a_cpu_stop: assert property (p_cpu_stop)
		else $error("cpu clock ran");
	property p_ref_off;
		!reference_clock_out_is_out && !$past(reference_clock_out_is_out, 2) |-> !clk_out[cgfs_pkg::REFERENCE_CLOCK_OUT_IDX];
	endproperty
	a_ref_off: assert property (p_ref_off) else $error("reference_clock_out driven");
	property p_fsel_hold;
		up_r == 4'hF && $changed(freq_idx) |-> act_r;
	endproperty
	a_fsel_hold: assert property (p_fsel_hold)
		else $error("code moved");
	c_wr: cover property (rise_w && bit_r == 4'h8 && byte_r == 4'h5 && !dir_r);
	c_rd: cover property (act_r && dir_r && sda_oe_s);
	c_pd: cover property (pd_r == 6'h1E);
endmodule : cgfs_asserts
`default_nettype wire

// file: dv/clockgen_i2c_freq_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module clockgen_i2c_freq_select_tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic mode_pin = 1'b0;
	logic cpu_stop_n = 1'b1;
	logic power_down_n = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [3:0] strap = 4'h4;
	logic [3:0] div = 4'h0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic [11:0] clk_src = 12'h000;
	logic [11:0] clk_out, cpu_mhz_x10, seen;
	logic [9:0] pci_mhz_x10;
	logic [3:0] freq_idx, code;
	logic [7:0] rdata, r0, got;
	logic [7:0] exp_r [3] = '{8'h00, 8'h0B, 8'hFF};
	logic reference_clock_out_is_out;
	int errors = 0;
	int tests_run = 0;
	int cyc = 0;
	cgfs_if lnk_if ();
	cgfs_dev cgfs_dev_inst (.clk(clk), .reset(reset), .lnk(lnk_if.slave),
		.hw_freq_strap_b0(strap[0]), .hw_freq_strap_b1(strap[1]),
		.hw_freq_strap_b2(strap[2]), .hw_freq_strap_b3(strap[3]),
		.pci_clock_out_zero(mode_pin), .cpu_stop_n(cpu_stop_n),
		.power_down_n(power_down_n), .clk_src(clk_src), .clk_out(clk_out),
		.freq_idx(freq_idx), .cpu_mhz_x10(cpu_mhz_x10),
		.pci_mhz_x10(pci_mhz_x10), .reference_clock_out_is_out(reference_clock_out_is_out));
	cgfs_host cgfs_host_inst (.clk(clk), .reset(reset), .lnk(lnk_if.master),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	cgfs_asserts cgfs_asserts_inst (.clk(clk), .reset(reset),
		.scl(lnk_if.scl), .sda(lnk_if.sda), .sda_oe_s(lnk_if.sda_oe_s),
		.clk_src(clk_src), .clk_out(clk_out), .freq_idx(freq_idx),
		.reference_clock_out_is_out(reference_clock_out_is_out), .cpu_stop_n(cpu_stop_n),
		.power_down_n(power_down_n));
	// ----------------------------------------
	// clock, sources and hang guard
	// ----------------------------------------
	always #10 clk = ~clk;
	// sources of period 4, 8 and 16 so every gate sees a low phase soon
	always @(posedge clk) begin
		div <= div + 4'h1;
		clk_src <= {4{div[3:1]}};
	end
	// a full run needs about 70000 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 85000) begin
			errors++;
			$display("Error at %0t: run timed out", $time);
			finish_test();
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic finish_test();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: byte %h expected %h", $time, g, e);
		end
	endtask : chk_reg
	task automatic chk_val(input logic [11:0] g, input logic [11:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: value %h expected %h", $time, g, e);
		end
	endtask : chk_val
	task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bus_wr
	// read data stands only in the cycle after the strobe
	task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask : bus_rd
	// one link transfer of three data bytes, polled until the host is idle
	task automatic xfer(input logic dir);
		logic [7:0] st;
		bus_wr(cgfs_pkg::H_CTRL, {4'h3, 2'b00, dir, 1'b1});
		st = 8'h01;
		for (int i = 0; i < 30000 && st[0] !== 1'b0; i++) begin
			bus_rd(cgfs_pkg::H_STAT, st);
		end
		chk_reg(st, 8'h00);
	endtask : xfer
	task automatic readback();
		xfer(1'b1);
		for (int i = 0; i < 3; i++) begin
			bus_rd(cgfs_pkg::H_DATA0 + 4'(i), got);
			chk_reg(got, exp_r[i]);
		end
	endtask : readback
	// ors the outputs over two slowest source periods after a settle
	task automatic watch(input int w);
		repeat (w) @(posedge clk);
		seen = 12'h000;
		repeat (32) begin
			@(posedge clk);
			seen = seen | clk_out;
		end
	endtask : watch
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(73681));
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		// settle stands in for the oscillator wait before outputs matter
		repeat (10) @(posedge clk);
		strap <= 4'($urandom());
		watch(8);
		chk_val({8'h00, freq_idx}, 12'h004);
		chk_val(cpu_mhz_x10, 12'h29C);
		chk_val({2'b00, pci_mhz_x10}, 12'h14E);
		chk_val({11'h000, reference_clock_out_is_out}, 12'h000);
		chk_val(seen & 12'h403, 12'h003);
		cpu_stop_n <= 1'b0;
		watch(24);
		chk_val(seen & 12'h007, 12'h004);
		cpu_stop_n <= 1'b1;
		power_down_n <= 1'b0;
		watch(24);
		chk_val(seen, 12'h000);
		power_down_n <= 1'b1;
		watch(24);
		chk_val(seen & 12'h007, 12'h007);
		readback();
		// reserved bits written as ones must read back as zero
		code = 4'($urandom());
		r0 = {1'b1, code[2:0], 1'b1, code[3], 2'b11};
		bus_wr(cgfs_pkg::H_DATA0, r0);
		bus_wr(cgfs_pkg::H_DATA0 + 4'h1, 8'h0B);
		bus_wr(cgfs_pkg::H_DATA0 + 4'h2, 8'h00);
		xfer(1'b0);
		watch(8);
		chk_val({8'h00, freq_idx}, {8'h00, code});
		chk_val(cpu_mhz_x10, cgfs_pkg::CPU_X10[code]);
		chk_val({2'b00, pci_mhz_x10}, {2'b00, cgfs_pkg::PCI_X10[code]});
		chk_val(seen & 12'h0FF, 12'h003);
		// byte 2 keeps its reserved ones from power-up
		exp_r = '{r0 & 8'h7C, 8'h0B, 8'hA0};
		readback();
		// second power-up with the mode strap high: reference_clock_out runs, stop ignored
		reset <= 1'b1;
		mode_pin <= 1'b1;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		repeat (10) @(posedge clk);
		cpu_stop_n <= 1'b0;
		watch(24);
		chk_val({11'h000, reference_clock_out_is_out}, 12'h001);
		chk_val({8'h00, freq_idx}, {8'h00, strap});
		chk_val(seen & 12'hC03, 12'hC03);
		cpu_stop_n <= 1'b1;
		finish_test();
	end
endmodule : clockgen_i2c_freq_select_tb_top
`default_nettype wire
